// ---- prot_pkg.sv ----
// Overview of operation
// - option bits only program from one to zero
// - only whole erase restores option bits to one
// - option byte at loader top, programming mode only
// - cleared lock refuses memory and option reads
// - inhibit low: external table reads stay external
// - internal table reads reach both memories always
// - inhibit high: no table read restriction
// - encryption on: port bytes pass encoder
// - encryption cleared only by whole erase
// - gain bit zero asserts half gain output
// - fully static, state kept with stopped clock
package prot_pkg;

  // ------------------------------------------------------------
  // address map and option byte layout
  // ------------------------------------------------------------
  localparam logic [15:0] OPTION_ADDR   = 16'hffff;  // top of loader space
  localparam int          LOCK_POS      = 0;         // read lock
  localparam int          INHIBIT_POS   = 1;         // table read inhibit
  localparam int          ENCRYPT_POS   = 2;         // encryption, active low
  localparam int          GAIN_POS      = 7;         // gain reduce bit
  localparam logic [7:0]  OPTION_ERASED = 8'hff;     // erased value
  localparam logic [7:0]  REFUSED_DATA  = 8'hff;     // data shown when refused
  localparam logic [7:0]  KEY_DEFAULT   = 8'h5a;     // encoder xor key
  localparam logic [2:0]  ROT_DEFAULT   = 3'h3;      // encoder rotate amount

  // ------------------------------------------------------------
  // programmer command set
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE  = 2'h0,
    CMD_READ  = 2'h1,
    CMD_PROG  = 2'h2,
    CMD_ERASE = 2'h3
  } prog_cmd_t;

  // programmer request bundle
  typedef struct packed {
    logic        valid;
    prog_cmd_t   cmd;
    logic        loader;  // loader space selected
    logic [15:0] addr;
    logic [7:0]  wdata;
  } prog_req_t;

  // answer bundle
  typedef struct packed {
    logic       valid;
    logic       refused;
    logic [7:0] rdata;
  } prog_rsp_t;

endpackage : prot_pkg

// ---- option_cell.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// one-time-clearable option byte cell
// ------------------------------------------------------------
module option_cell (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // update strobes
  input  wire logic       prog_en,
  input  wire logic [7:0] prog_data,
  input  wire logic       erase_en,
  // stored value
  output logic [7:0]      value
);

  // whole cell state
  typedef struct packed {
    logic [7:0] bits;
  } cell_state_t;

  cell_state_t st_reg;  // stored byte
  cell_state_t st_next; // next byte

  // next state: program can only clear, erase sets all
  always_comb
  begin
    st_next = st_reg;
    if (erase_en)
    begin
      st_next.bits = prot_pkg::OPTION_ERASED;
    end
    else if (prog_en)
    begin
      st_next.bits = st_reg.bits & prog_data;
    end
  end

  // nonvolatile in the real part, so reset leaves it alone; the
  // flop holds with any clock stall, nothing depends on clock rate
  always_ff @(posedge clk)
  begin
    st_reg <= st_next;
  end

  assign value = st_reg.bits;

  // only a real change is judged; a byte not yet erased gives no match
  AST_NO_RAISE: assert property (@(posedge clk) disable iff (sys_rst)
    (!$past(erase_en) && value != $past(value)) |-> ((value & ~$past(value)) == 8'h00))
    else $error("option bit rose without erase");

  AST_ERASE_SETS: assert property (@(posedge clk) disable iff (sys_rst)
    erase_en |=> value == prot_pkg::OPTION_ERASED)
    else $error("erase did not restore option byte");

endmodule : option_cell
`default_nettype wire

// ---- code_protection_fuses.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// code protection: option byte, read gating, table read
// restriction, port encoder, oscillator gain control
// ------------------------------------------------------------
module code_protection_fuses #(
  parameter logic [7:0] ENC_KEY = prot_pkg::KEY_DEFAULT,  // encoder key
  parameter logic [2:0] ENC_ROT = prot_pkg::ROT_DEFAULT   // encoder rotation
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // programmer side
  input  wire logic                  prog_mode,
  input  wire prot_pkg::prog_req_t   prog_req,
  input  wire logic [7:0]            mem_rdata,
  output prot_pkg::prog_rsp_t        prog_rsp,
  output logic                       mem_erase,
  // code table read path
  input  wire logic                  table_rd,
  input  wire logic                  table_from_ext,
  input  wire logic                  table_target_int,
  output logic                       table_int_allow,
  // muxed bus port output
  input  wire logic [7:0]            muxed_bus_raw,
  output logic [7:0]                 muxed_bus_port,
  // oscillator
  output logic                       half_gain
);

  // ------------------------------------------------------------
  // encoder functions
  // ------------------------------------------------------------
  // rotate left then xor: reversible by xor then rotate right
  function automatic logic [7:0] encode_byte(input logic [7:0] d);
    logic [15:0] dd;
    logic [7:0]  r;
    dd = {d, d} << ENC_ROT;
    r  = dd[15:8];
    return r ^ ENC_KEY;
  endfunction : encode_byte

  // inverse mapping, kept for reference and checking
  function automatic logic [7:0] decode_byte(input logic [7:0] e);
    logic [15:0] dd;
    logic [7:0]  x;
    x  = e ^ ENC_KEY;
    dd = {x, x} >> ENC_ROT;
    return dd[7:0];
  endfunction : decode_byte

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    prot_pkg::prog_rsp_t rsp;
    logic                erase;
    logic                int_allow;
    logic [7:0]          bus;
    logic                half_gain;
    logic                rd_pend;   // memory read waiting for data
  } top_state_t;

  top_state_t st_reg;   // registered state
  top_state_t st_next;  // next state

  logic [7:0] opt;      // option byte from the cell
  logic       opt_wr;   // program strobe to the cell
  logic       is_opt;   // request addresses the option byte
  logic       locked;   // lock bit cleared
  logic       inhibit;  // inhibit active
  logic       enc_on;   // encryption active
  logic       opt_erase; // erase strobe to the cell

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign is_opt  = prog_req.loader && (prog_req.addr == prot_pkg::OPTION_ADDR);
  assign locked  = !opt[prot_pkg::LOCK_POS];
  assign inhibit = !opt[prot_pkg::INHIBIT_POS];
  assign enc_on  = !opt[prot_pkg::ENCRYPT_POS];
  // option byte is only reachable in programming mode
  // the slot after an array read is ignored, and reset holds the cell
  assign opt_wr  = prog_mode && prog_req.valid && is_opt && !st_reg.rd_pend && !sys_rst
                   && (prog_req.cmd == prot_pkg::CMD_PROG);
  // erase reaches the cell only as a taken request, never inside reset
  assign opt_erase = st_next.erase && !sys_rst;

  // ------------------------------------------------------------
  // option byte storage
  // ------------------------------------------------------------
  option_cell u_cell (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .prog_en   (opt_wr),
    .prog_data (prog_req.wdata),
    .erase_en  (opt_erase),
    .value     (opt)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    st_next.rsp.valid = 1'b0;
    st_next.erase     = 1'b0;
    st_next.rd_pend   = 1'b0;
    // second cycle of a memory read returns array data
    if (st_reg.rd_pend)
    begin
      st_next.rsp.valid   = 1'b1;
      st_next.rsp.refused = 1'b0;
      st_next.rsp.rdata   = mem_rdata;
    end
    else if (prog_mode && prog_req.valid)
    begin
      case (prog_req.cmd)
        prot_pkg::CMD_READ:
        begin
          if (locked)
          begin
            // lock refuses memory and option reads alike
            st_next.rsp.valid   = 1'b1;
            st_next.rsp.refused = 1'b1;
            st_next.rsp.rdata   = prot_pkg::REFUSED_DATA;
          end
          else if (is_opt)
          begin
            st_next.rsp.valid   = 1'b1;
            st_next.rsp.refused = 1'b0;
            st_next.rsp.rdata   = opt;
          end
          else
          begin
            st_next.rd_pend = 1'b1;
          end
        end
        prot_pkg::CMD_PROG:
        begin
          // option writes handled by the cell, answer is an ack
          st_next.rsp.valid   = 1'b1;
          st_next.rsp.refused = 1'b0;
          st_next.rsp.rdata   = prot_pkg::REFUSED_DATA;
        end
        prot_pkg::CMD_ERASE:
        begin
          // whole chip erase, the only path back to erased bits
          st_next.erase       = 1'b1;
          st_next.rsp.valid   = 1'b1;
          st_next.rsp.refused = 1'b0;
          st_next.rsp.rdata   = prot_pkg::REFUSED_DATA;
        end
        default:
        begin
          st_next.rsp.valid = 1'b0;
        end
      endcase
    end
    // table reads from outside code may not touch internal memory while inhibit is active
    if (table_rd && table_from_ext && table_target_int)
    begin
      st_next.int_allow = !inhibit;
    end
    else
    begin
      st_next.int_allow = table_rd;
    end
    // port output path, bypassed while encryption is off
    st_next.bus = enc_on ? encode_byte(muxed_bus_raw) : muxed_bus_raw;
    st_next.half_gain = !opt[prot_pkg::GAIN_POS];
  end

  // ------------------------------------------------------------
  // registers; static flops, a stopped clock only pauses them
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // option bits survive reset, only volatile state clears
      st_reg.rsp       <= '0;
      st_reg.erase     <= 1'b0;
      st_reg.int_allow <= 1'b0;
      st_reg.bus       <= 8'h00;
      st_reg.half_gain <= 1'b0;
      st_reg.rd_pend   <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prog_rsp        = st_reg.rsp;
  assign mem_erase       = st_reg.erase;
  assign table_int_allow = st_reg.int_allow;
  assign muxed_bus_port  = st_reg.bus;
  assign half_gain       = st_reg.half_gain;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // any read taken from the programmer
  sequence s_read_req;
    prog_mode && prog_req.valid && prog_req.cmd == prot_pkg::CMD_READ;
  endsequence

  // option byte read with the lock open, answered next cycle
  sequence s_opt_read;
    s_read_req ##0 (is_opt && !locked && !st_reg.rd_pend);
  endsequence

  // array read with the lock open, data sampled one cycle later
  sequence s_array_read;
    s_read_req ##0 (!is_opt && !locked && !st_reg.rd_pend);
  endsequence

  // quiet cycle, then the array byte comes back
  sequence s_array_answer;
    !prog_rsp.valid ##1 (prog_rsp.valid && !prog_rsp.refused && prog_rsp.rdata == $past(mem_rdata));
  endsequence

  // whole erase taken this cycle
  sequence s_erase_req;
    prog_mode && prog_req.valid && prog_req.cmd == prot_pkg::CMD_ERASE && !st_reg.rd_pend;
  endsequence

  // a locked read is answered, but only with a refusal
  AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (sys_rst)
    (s_read_req and (locked && !st_reg.rd_pend)) |=> prog_rsp.valid && prog_rsp.refused)
    else $error("read answered while locked");

  // a locked read never starts an array fetch
  AST_LOCK_NO_FETCH: assert property (@(posedge clk) disable iff (sys_rst)
    (s_read_req and locked) |-> !st_next.rd_pend)
    else $error("array fetched while locked");

  // open option read returns the stored byte
  AST_OPT_READ: assert property (@(posedge clk) disable iff (sys_rst)
    s_opt_read |=> prog_rsp.valid && !prog_rsp.refused && prog_rsp.rdata == $past(opt))
    else $error("option byte read answered wrongly");

  // open array read returns the array byte two cycles on
  AST_ARRAY_READ: assert property (@(posedge clk) disable iff (sys_rst)
    s_array_read |=> s_array_answer)
    else $error("array read answered wrongly");

  // erase gives an answer and one strobe to the array
  AST_ERASE_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    s_erase_req |=> mem_erase && prog_rsp.valid && !prog_rsp.refused)
    else $error("erase not passed to the array");

  // outside programming mode, with no array read pending, nothing is answered or erased
  AST_NO_MODE_SILENT: assert property (@(posedge clk) disable iff (sys_rst)
    (!prog_mode && !st_reg.rd_pend) |=> !prog_rsp.valid && !mem_erase)
    else $error("request served outside programming mode");

  // option byte only moves in programming mode or by erase
  AST_OPT_MODE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
    (!prog_mode && $past(!prog_mode)) |=> $stable(opt) || $past(st_next.erase))
    else $error("option byte changed outside programming mode");

  // outside code may not reach internal memory under inhibit
  AST_EXT_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    (table_rd && table_from_ext && table_target_int && inhibit) |=> !table_int_allow)
    else $error("external table read reached internal memory");

  // inside code reaches both memories
  AST_INT_ALWAYS: assert property (@(posedge clk) disable iff (sys_rst)
    (table_rd && !table_from_ext) |=> table_int_allow)
    else $error("internal table read restricted");

  // no restriction with inhibit off
  AST_NO_INHIBIT: assert property (@(posedge clk) disable iff (sys_rst)
    (table_rd && !inhibit) |=> table_int_allow)
    else $error("table read restricted with inhibit off");

  // port byte decodes back to the raw byte
  AST_ENCODE: assert property (@(posedge clk) disable iff (sys_rst)
    enc_on |=> decode_byte(muxed_bus_port) == $past(muxed_bus_raw))
    else $error("port byte not encoded");

  // port byte passes untouched with encryption off
  AST_BYPASS: assert property (@(posedge clk) disable iff (sys_rst)
    !enc_on |=> muxed_bus_port == $past(muxed_bus_raw))
    else $error("port byte altered with encryption off");

  // encryption stays on until an erase
  AST_ENC_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
    (enc_on && !st_next.erase) |=> enc_on)
    else $error("encryption cleared without erase");

  // cleared gain bit gives half gain next cycle
  AST_GAIN_HALF: assert property (@(posedge clk) disable iff (sys_rst)
    !opt[prot_pkg::GAIN_POS] |=> half_gain)
    else $error("half gain missing with gain bit cleared");

  // set gain bit keeps full gain
  AST_GAIN_FULL: assert property (@(posedge clk) disable iff (sys_rst)
    opt[prot_pkg::GAIN_POS] |=> !half_gain)
    else $error("half gain shown with gain bit set");

endmodule : code_protection_fuses
`default_nettype wire

// ---- programmer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// programmer stand-in and array
// ------------------------------
module programmer_model (
  // clock
  input  wire logic                clk,
  // block links
  output var prot_pkg::prog_req_t  req,
  output logic [7:0]               arr_data,
  input  wire prot_pkg::prog_rsp_t rsp
);
  // array content stand-in, keyed by address
  function automatic logic [7:0] arr_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : arr_val
  // idle request at start
  initial
  begin
    req      = '0;
    arr_data = 8'ha5;
  end
  // one request for one edge, answer awaited over three edges
  task automatic op(input prot_pkg::prog_cmd_t c, input logic l, input logic [15:0] a,
                    input logic [7:0] w, output logic s, output logic f, output logic [7:0] d);
    s = 1'b0;
    @(posedge clk);
    req      <= '{1'b1, c, l, a, w};
    arr_data <= arr_val(a);
    @(posedge clk);
    req.valid <= 1'b0;
    for (int k = 0; k < 3; k++)
    begin
      #1;
      if (!s && rsp.valid === 1'b1)
      begin
        s = 1'b1;
        f = rsp.refused;
        d = rsp.rdata;
      end
      @(posedge clk);
      // array byte holds over the fetch edge, then no stale byte remains
      if (k == 0) arr_data <= ~arr_val(a);
    end
  endtask : op
endmodule : programmer_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ------------------------------
  // stimulus, links, bookkeeping
  // ------------------------------
  logic                clk, clk_run, sys_rst, prog_mode;
  logic                table_rd, table_from_ext, table_target_int;
  logic [7:0]          muxed_bus_raw, muxed_bus_port, mem_rdata, rd;
  logic                mem_erase, table_int_allow, half_gain, seen, refd;
  prot_pkg::prog_req_t prog_req;
  prot_pkg::prog_rsp_t prog_rsp;
  int                  opt, mismatches, comparisons, erase_cnt, cycles;
  // clock may be held still to test static state
  initial
  begin
    clk = 1'b0;
    forever #50 if (clk_run) clk = ~clk;
  end
  code_protection_fuses dut_u (.clk(clk), .sys_rst(sys_rst), .prog_mode(prog_mode),
    .prog_req(prog_req), .mem_rdata(mem_rdata), .prog_rsp(prog_rsp), .mem_erase(mem_erase),
    .table_rd(table_rd), .table_from_ext(table_from_ext), .table_target_int(table_target_int),
    .table_int_allow(table_int_allow), .muxed_bus_raw(muxed_bus_raw),
    .muxed_bus_port(muxed_bus_port), .half_gain(half_gain));
  programmer_model pm (.clk(clk), .req(prog_req), .arr_data(mem_rdata), .rsp(prog_rsp));
  // erase pulse count and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (mem_erase === 1'b1) erase_cnt++;
    if (cycles == 2000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_flag(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  // ------------------------------
  // bench model helpers
  // ------------------------------
  function automatic logic [7:0] enc(input logic [7:0] b);
    logic [15:0] t;
    t = {b, b} << prot_pkg::ROT_DEFAULT;
    return t[15:8] ^ prot_pkg::KEY_DEFAULT;
  endfunction : enc
  // read option byte or array, refused while lock bit is zero
  task automatic mem_read(input logic l, input logic [15:0] a);
    logic lk;
    logic [7:0] e;
    lk = (opt[0] == 0);
    e  = (l && a == prot_pkg::OPTION_ADDR) ? 8'(opt) : pm.arr_val(a);
    pm.op(prot_pkg::CMD_READ, l, a, 8'h00, seen, refd, rd);
    chk_flag("answer", 1'b1, seen);
    chk_flag("refused", lk, refd);
    chk_byte("rdata", lk ? prot_pkg::REFUSED_DATA : e, rd);
  endtask : mem_read
  // program option byte: bits only fall
  task automatic opt_prog(input logic [7:0] w);
    pm.op(prot_pkg::CMD_PROG, 1'b1, prot_pkg::OPTION_ADDR, w, seen, refd, rd);
    opt = opt & w;
    chk_flag("prog answer", 1'b1, seen);
  endtask : opt_prog
  task automatic erase_all();
    int e0;
    e0 = erase_cnt;
    pm.op(prot_pkg::CMD_ERASE, 1'b1, prot_pkg::OPTION_ADDR, 8'h00, seen, refd, rd);
    opt = 255;
    chk_flag("erase answer", 1'b1, seen);
    chk_flag("one erase pulse", 1'b1, erase_cnt - e0 == 1);
  endtask : erase_all
  // table read gate, port encoder and gain, one cycle after input
  task automatic side_chk();
    logic [7:0] raw;
    for (int x = 0; x < 2; x++)
    begin
      raw = 8'($urandom);
      @(posedge clk);
      muxed_bus_raw    <= raw;
      table_rd         <= 1'b1;
      table_from_ext   <= x[0];
      table_target_int <= 1'b1;
      @(posedge clk);
      #1;
      chk_flag("int allow", !x[0] || opt[1], table_int_allow);
      chk_byte("port", opt[2] ? raw : enc(raw), muxed_bus_port);
      chk_flag("half gain", !opt[7], half_gain);
    end
  endtask : side_chk
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    void'($urandom(31));
    {clk_run, sys_rst, prog_mode} = 3'h7;
    {table_rd, table_from_ext, table_target_int, muxed_bus_raw} = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    erase_all();
    mem_read(1'b1, prot_pkg::OPTION_ADDR);
    side_chk();
    for (int i = 0; i < 6; i++)
    begin
      opt_prog(8'($urandom) | 8'h01);
      opt_prog(8'hff);
      mem_read(1'b1, prot_pkg::OPTION_ADDR);
      mem_read(1'b0, 16'($urandom));
      side_chk();
    end
    opt_prog(8'hfb);
    prog_mode <= 1'b0;
    pm.op(prot_pkg::CMD_PROG, 1'b1, prot_pkg::OPTION_ADDR, 8'h00, seen, refd, rd);
    chk_flag("prog outside mode", 1'b0, seen);
    prog_mode <= 1'b1;
    sys_rst   <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    mem_read(1'b1, prot_pkg::OPTION_ADDR);
    side_chk();
    @(posedge clk);
    #10 clk_run = 1'b0;
    #20000 clk_run = 1'b1;
    mem_read(1'b1, prot_pkg::OPTION_ADDR);
    // lock only after the reads above have verified the byte
    opt_prog(8'hfe);
    mem_read(1'b1, prot_pkg::OPTION_ADDR);
    mem_read(1'b0, 16'h1234);
    erase_all();
    mem_read(1'b1, prot_pkg::OPTION_ADDR);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
